// file: rtl/gyro_port_device.sv
// Sensor end: four-wire and two-wire slave port with the register map.
// Assumes link pins are asynchronous to clk_sys and sample pulses are on clk_sys.
// Overview of operation
// (R1) Rate samples are two's complement, zero at rest
// (R2) High byte sign plus d11..d7, low d6..d0
// (R3) Two-wire address register, six bits, resets 0Fh
// (R4) Address LSB comes from serial-out pin level
// (R5) Select picks link; control bit disables two-wire
// (R6) Frame: six address bits, direction, zero, data
// (R7) Direction bit: 0 read, 1 write
// (R8) Sample input on rise, change output on fall
// (R9) First byte out: x,0,por,por,por,0,1,0
// (R10) Writes return zeros in the data byte
// (R11) Write commits on sixteenth falling edge
// (R12) Read data loaded at eighth rise, MSB first
// (R13) Serial out released while select is high
// (R14) Rate burst reads decrement, 0Ch wraps 11h
// (R15) Every two-wire read decrements the pointer
// (R16) Data fall with clock high means start
// (R17) Two-wire disable bit resets to zero
// (R18) Rate outputs refresh only while select high
// (R19) Seven-bit two-wire slave with start, stop
// (R20) Two-wire write: register address, then data
// (R21) Two-wire pointer write to rate refreshes them
// (R22) Early select rise abandons frame, no write
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "gyro_link_map.svh"
module gyro_port_device #(
	parameter logic [7:0] TRIM_VALUE = 8'h00
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	gyro_link_if.device               link,
	input  wire logic [`RATE_W-1:0]   rate_x,
	input  wire logic [`RATE_W-1:0]   rate_y,
	input  wire logic [`RATE_W-1:0]   rate_z,
	input  wire logic                 sample_valid,
	output logic      [7:0]           control_out
);
	gyro_link_pkg::dev_state_t s, n;
	logic [3:0] pins;
	logic [3:0] fn;
	logic       sck_rise, sck_fall, sda_rise, sda_fall, sel_rise, sel_fall;
	logic       start_c, stop_c, i2c_on, we, rd_stat;
	logic [5:0] wa;
	logic [7:0] wd, v, b;

	// Rate word to register pair {high, low}
	function automatic logic [15:0] fmt(input logic [`RATE_W-1:0] r);
		fmt = {2'h0, r[`RATE_W-1:7], r[6:0], 1'h0}; // [R1] [R2]
	endfunction

	function automatic logic in_rate(input logic [5:0] a);
		in_rate = (a >= `REG_RATE_FIRST) && (a <= `REG_RATE_LAST);
	endfunction

	function automatic logic [5:0] dec(input logic [5:0] a);
		dec = (a == `REG_RATE_FIRST) ? `REG_RATE_LAST : a - 6'h01; // [R14] [R15]
	endfunction

	function automatic logic [7:0] rd(input logic [5:0] a, input gyro_link_pkg::dev_state_t st);
		case (a)
			`REG_CONTROL: rd = st.ctrl;
			`REG_STATUS:  rd = 8'(st.por) << `STAT_POR_BIT;
			`REG_TWA:     rd = {2'h0, st.twa}; // [R3]
			`REG_TRIM:    rd = TRIM_VALUE;
			default:      rd = in_rate(a) ? st.outr[{3'(a - `REG_RATE_FIRST), 3'h0} +: 8] : 8'h00;
		endcase
	endfunction

	assign pins = {link.sck, link.select_n, link.sda, link.miso};

	// Pin filter: a change counts once the last two stages agree
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			assign fn[gi] = (s.m2[gi] == s.m3[gi]) ? s.m3[gi] : s.f[gi];
		end
	endgenerate

	assign sck_rise = fn[`PIN_SCK] & ~s.f[`PIN_SCK];
	assign sck_fall = ~fn[`PIN_SCK] & s.f[`PIN_SCK];
	assign sda_rise = fn[`PIN_SDA] & ~s.f[`PIN_SDA];
	assign sda_fall = ~fn[`PIN_SDA] & s.f[`PIN_SDA];
	assign sel_rise = fn[`PIN_SEL] & ~s.f[`PIN_SEL];
	assign sel_fall = ~fn[`PIN_SEL] & s.f[`PIN_SEL];
	assign start_c  = sda_fall & s.f[`PIN_SCK] & fn[`PIN_SCK]; // [R16]
	assign stop_c   = sda_rise & s.f[`PIN_SCK] & fn[`PIN_SCK];
	assign i2c_on   = ~s.ctrl[`CTRL_TWD_BIT] & s.f[`PIN_SEL]; // [R5]

	always_comb begin
		n = s;
		we = 1'b0;
		wa = 6'h00;
		wd = 8'h00;
		rd_stat = 1'b0;
		v = 8'h00;
		b = {s.ish[6:0], fn[`PIN_SDA]};
		n.m1 = pins;
		n.m2 = s.m1;
		n.m3 = s.m2;
		n.f = fn;
		if (sample_valid) begin
			n.live = {rate_z, rate_y, rate_x};
		end
		if (s.f[`PIN_SEL] && s.ist == gyro_link_pkg::I_IDLE) begin
			n.outr = {fmt(s.live[2*`RATE_W +: `RATE_W]), fmt(s.live[`RATE_W +: `RATE_W]),
				fmt(s.live[0 +: `RATE_W])}; // [R18]
		end
		// Four-wire frame
		if (sel_rise) begin
			n.bcnt = 5'h00; // [R22]
			n.hold_v = 1'b0;
		end else if (sel_fall) begin
			n.bcnt = 5'h00;
			n.hold_v = 1'b0;
			n.tx = `PFX_FIXED | ({8{s.por}} & `PFX_POR_MASK); // [R9]
		end else if (!s.f[`PIN_SEL]) begin
			if (sck_rise) begin
				n.rx = {s.rx[6:0], fn[`PIN_SDA]}; // [R8]
				if (s.bcnt != `SPI_FRAME_BITS) begin
					n.bcnt = s.bcnt + 5'h01;
				end
				if (s.bcnt == `SPI_CMD_BITS - 5'h01) begin
					n.addr = s.rx[6:1]; // [R6]
					n.dir = s.rx[0]; // [R7]
					n.hold = s.rx[0] ? 8'h00 : rd(s.rx[6:1], s); // [R10] [R12]
					n.hold_v = 1'b1;
					rd_stat = ~s.rx[0] && s.rx[6:1] == `REG_STATUS;
				end else if (s.bcnt == `SPI_FRAME_BITS - 5'h01 && !s.dir && in_rate(s.addr)) begin
					n.addr = dec(s.addr); // [R14]
					n.hold = rd(dec(s.addr), s);
					n.hold_v = 1'b1;
					n.bcnt = `SPI_CMD_BITS;
				end
			end
			if (sck_fall) begin
				if (s.hold_v) begin
					n.tx = s.hold; // [R12]
					n.hold_v = 1'b0;
				end else begin
					n.tx = {s.tx[6:0], 1'b0}; // [R8]
				end
				if (s.bcnt == `SPI_FRAME_BITS) begin
					we = s.dir; // [R11]
					wa = s.addr;
					wd = s.rx;
					n.bcnt = 5'h00;
					n.tx = `PFX_FIXED | ({8{s.por}} & `PFX_POR_MASK);
				end
			end
		end
		// Two-wire slave
		if (!i2c_on) begin
			n.ist = gyro_link_pkg::I_IDLE;
			n.sda_oe = 1'b0;
			n.ack_go = 1'b0;
			n.in_ack = 1'b0;
		end else if (start_c) begin
			n.ist = gyro_link_pkg::I_ADDR; // [R19]
			n.icnt = 4'h0;
			n.sda_oe = 1'b0;
			n.ack_go = 1'b0;
			n.in_ack = 1'b0;
			n.strap = s.f[`PIN_MISO]; // [R4]
		end else if (stop_c) begin
			n.ist = gyro_link_pkg::I_IDLE;
			n.sda_oe = 1'b0;
			n.ack_go = 1'b0;
			n.in_ack = 1'b0;
		end else begin
			if (sck_rise && !s.in_ack && !s.ack_go) begin
				case (s.ist)
					gyro_link_pkg::I_ADDR, gyro_link_pkg::I_REG, gyro_link_pkg::I_WDATA: begin
						n.ish = b;
						n.icnt = s.icnt + 4'h1;
						if (s.icnt == `I2C_BYTE_BITS - 4'h1) begin
							n.ack_go = 1'b1;
							case (s.ist)
								gyro_link_pkg::I_ADDR: begin
									if (b[7:1] == {s.twa, s.strap}) begin // [R3] [R4] [R19]
										n.inext = b[0] ? gyro_link_pkg::I_RDATA : gyro_link_pkg::I_REG;
									end else begin
										n.ist = gyro_link_pkg::I_IDLE;
										n.ack_go = 1'b0;
									end
								end
								gyro_link_pkg::I_REG: begin
									n.ptr = b[5:0]; // [R20]
									n.inext = gyro_link_pkg::I_WDATA;
									if (in_rate(b[5:0])) begin
										n.outr = {fmt(s.live[2*`RATE_W +: `RATE_W]),
											fmt(s.live[`RATE_W +: `RATE_W]),
											fmt(s.live[0 +: `RATE_W])}; // [R21]
									end
								end
								default: begin
									we = 1'b1; // [R20]
									wa = s.ptr;
									wd = b;
									n.inext = gyro_link_pkg::I_WDATA;
								end
							endcase
						end
					end
					gyro_link_pkg::I_RDATA: begin
						if (s.icnt == `I2C_BYTE_BITS) begin
							if (!fn[`PIN_SDA]) begin
								n.itx = rd(s.ptr, s);
								rd_stat = s.ptr == `REG_STATUS;
								n.ptr = dec(s.ptr); // [R15]
								n.icnt = 4'h0;
							end else begin
								n.ist = gyro_link_pkg::I_IDLE;
							end
						end else begin
							n.icnt = s.icnt + 4'h1;
						end
					end
					default: begin
					end
				endcase
			end
			if (sck_fall) begin
				if (s.ack_go) begin
					n.sda_oe = 1'b1;
					n.ack_go = 1'b0;
					n.in_ack = 1'b1;
				end else if (s.in_ack) begin
					n.in_ack = 1'b0;
					n.icnt = 4'h0;
					n.ist = s.inext;
					n.sda_oe = 1'b0;
					if (s.inext == gyro_link_pkg::I_RDATA) begin
						v = rd(s.ptr, s);
						rd_stat = s.ptr == `REG_STATUS;
						n.ptr = dec(s.ptr); // [R15]
						n.sda_oe = ~v[7];
						n.itx = {v[6:0], 1'b0};
					end
				end else if (s.ist == gyro_link_pkg::I_RDATA) begin
					n.sda_oe = (s.icnt < `I2C_BYTE_BITS) ? ~s.itx[7] : 1'b0;
					n.itx = {s.itx[6:0], 1'b0};
				end
			end
		end
		if (we) begin
			case (wa)
				`REG_CONTROL: n.ctrl = wd & `CTRL_WMASK;
				`REG_TWA:     n.twa = wd[5:0];
				default: begin
				end
			endcase
		end
		if (rd_stat) begin
			n.por = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s <= '0;
			s.m1 <= 4'h6;
			s.m2 <= 4'h6;
			s.m3 <= 4'h6;
			s.f <= 4'h6;
			s.ctrl <= `CTRL_RESET; // [R17]
			s.twa <= `TWA_RESET; // [R3]
			s.por <= 1'b1;
			s.ist <= gyro_link_pkg::I_IDLE;
			s.inext <= gyro_link_pkg::I_IDLE;
		end else begin
			s <= n;
		end
	end

	assign link.miso_o = s.tx[7];
	assign link.miso_oe = ~s.f[`PIN_SEL]; // [R13]
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = s.sda_oe;
	assign control_out = s.ctrl;
endmodule // gyro_port_device
`default_nettype wire

// file: rtl/gyro_link_map.svh
// Register map, field positions and timing counts of the gyro serial port.
// Assumes inclusion by both ends and by the package users.
`ifndef GYRO_LINK_MAP_SVH
`define GYRO_LINK_MAP_SVH
`define REG_CONTROL     6'h02
`define REG_STATUS      6'h03
`define REG_RATE_FIRST  6'h0C
`define REG_RATE_LAST   6'h11
`define REG_TWA         6'h22
`define REG_TRIM        6'h26
`define CTRL_TWD_BIT    4
`define CTRL_WMASK      8'hD7
`define CTRL_RESET      8'h00
`define STAT_POR_BIT    3
`define TWA_RESET       6'h0F
`define PFX_FIXED       8'h02
`define PFX_POR_MASK    8'h38
`define RATE_W          13
`define SPI_CMD_BITS    5'h08
`define SPI_FRAME_BITS  5'h10
`define I2C_BYTE_BITS   4'h8
`define PIN_MISO        0
`define PIN_SDA         1
`define PIN_SEL         2
`define PIN_SCK         3
`define HOST_CMD        8'h00
`define HOST_STATUS     8'h04
`define HOST_DEV        8'h08
`define HOST_DEV_RESET  7'h1E
`define HOST_Q_CYC      8
`define HOST_Q_MIN      6
`endif

// file: rtl/gyro_link_pkg.sv
// Types shared by both ends of the gyro serial link.
// Assumes gyro_link_map.svh for the rate width.
`include "gyro_link_map.svh"
package gyro_link_pkg;
	typedef enum logic [2:0] {
		I_IDLE  = 3'b000,
		I_ADDR  = 3'b001,
		I_REG   = 3'b010,
		I_WDATA = 3'b011,
		I_RDATA = 3'b100
	} i2c_st_t;
	typedef enum logic {
		H_IDLE = 1'b0,
		H_RUN  = 1'b1
	} host_phase_t;
	typedef enum logic [2:0] {
		K_CS_ON  = 3'b000,
		K_CS_OFF = 3'b001,
		K_START  = 3'b010,
		K_STOP   = 3'b011,
		K_BYTE   = 3'b100,
		K_RBYTE  = 3'b101,
		K_END    = 3'b110
	} sym_kind_t;
	typedef struct packed {
		sym_kind_t  kind;
		logic [7:0] data;
	} sym_t;
	typedef struct packed {
		logic [3:0]            m1, m2, m3, f;
		logic [3*`RATE_W-1:0]  live;
		logic [47:0]           outr;
		logic [7:0]            ctrl;
		logic [5:0]            twa;
		logic                  por;
		logic [4:0]            bcnt;
		logic [7:0]            rx, tx, hold;
		logic                  hold_v, dir;
		logic [5:0]            addr;
		i2c_st_t               ist, inext;
		logic [3:0]            icnt;
		logic [7:0]            ish, itx;
		logic [5:0]            ptr;
		logic                  ack_go, in_ack, sda_oe, strap;
	} dev_state_t;
	typedef struct packed {
		logic [1:0]  m1, m2, m3, f;
		host_phase_t ph;
		logic        i2c, wr, nack;
		logic [5:0]  raddr;
		logic [7:0]  wdata, rdata, prefix, qcnt;
		logic [6:0]  dev;
		logic [2:0]  step;
		logic [3:0]  bb;
		logic [1:0]  q;
		logic [15:0] sh;
		logic        sck, sel_n, d, oe, err;
		logic [31:0] prdata;
	} host_state_t;
endpackage

// file: rtl/gyro_link_if.sv
// Serial link between the gyro port and its controller.
// Assumes the bench drives miso_strap, the level of the undriven serial-out pin.
`timescale 1ns/1ns
`default_nettype none
interface gyro_link_if;
	logic sck;
	logic select_n;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic miso_o;
	logic miso_oe;
	logic miso_strap;
	logic sda;
	logic miso;
	// Shared data pin: pulled high, either end may pull it
	assign sda  = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	assign miso = miso_oe ? miso_o : miso_strap;
	modport device (input sck, select_n, sda, miso, output dev_sda_o, dev_sda_oe, miso_o, miso_oe);
	modport host (output sck, select_n, host_sda_o, host_sda_oe, input sda, miso);
endinterface
`default_nettype wire

// file: rtl/gyro_port_host.sv
// Controller end: APB registers drive four-wire or two-wire transfers to the sensor.
// Assumes APB on clk_sys; the sensor samples the link with its own clock.
`timescale 1ns/1ns
`default_nettype none
`include "gyro_link_map.svh"
module gyro_port_host #(
	parameter int Q_CYC = `HOST_Q_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	gyro_link_if.host        link,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	gyro_link_pkg::host_state_t s, n;
	gyro_link_pkg::sym_t        sy;
	logic [1:0] fn;
	logic       tick, last_bit, bv;

	generate
		if (Q_CYC < `HOST_Q_MIN || Q_CYC > 255) begin : g_chk
			$error("Q_CYC out of range");
		end
	endgenerate

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			assign fn[gi] = (s.m2[gi] == s.m3[gi]) ? s.m3[gi] : s.f[gi];
		end
	endgenerate

	// Symbol sequence of one transfer
	function automatic gyro_link_pkg::sym_t sym(input gyro_link_pkg::host_state_t st);
		sym = '{gyro_link_pkg::K_END, 8'h00};
		if (!st.i2c) begin
			case (st.step)
				3'h0: sym.kind = gyro_link_pkg::K_CS_ON;
				3'h1: sym = '{gyro_link_pkg::K_BYTE, {st.raddr, st.wr, 1'b0}}; // [R6] [R7]
				3'h2: sym = '{gyro_link_pkg::K_BYTE, st.wr ? st.wdata : 8'h00};
				3'h3: sym.kind = gyro_link_pkg::K_CS_OFF;
				default: sym.kind = gyro_link_pkg::K_END;
			endcase
		end else begin
			case (st.step)
				3'h0: sym.kind = gyro_link_pkg::K_START;
				3'h1: sym = '{gyro_link_pkg::K_BYTE, {st.dev, 1'b0}};
				3'h2: sym = '{gyro_link_pkg::K_BYTE, {2'h0, st.raddr}}; // [R20]
				3'h3: sym = st.wr ? '{gyro_link_pkg::K_BYTE, st.wdata} : '{gyro_link_pkg::K_START, 8'h00};
				3'h4: sym = st.wr ? '{gyro_link_pkg::K_STOP, 8'h00} : '{gyro_link_pkg::K_BYTE, {st.dev, 1'b1}};
				3'h5: sym.kind = st.wr ? gyro_link_pkg::K_END : gyro_link_pkg::K_RBYTE;
				3'h6: sym.kind = st.wr ? gyro_link_pkg::K_END : gyro_link_pkg::K_STOP;
				default: sym.kind = gyro_link_pkg::K_END;
			endcase
		end
	endfunction

	assign tick = s.qcnt == 8'(Q_CYC - 1);
	assign sy = sym(s);
	assign last_bit = s.bb == (s.i2c ? `I2C_BYTE_BITS : `I2C_BYTE_BITS - 4'h1);

	always_comb begin
		n = s;
		bv = 1'b1;
		n.m1 = {link.sda, link.miso};
		n.m2 = s.m1;
		n.m3 = s.m2;
		n.f = fn;
		// APB: read data and error captured in the setup cycle
		if (psel && !penable) begin
			n.err = paddr != `HOST_CMD && paddr != `HOST_STATUS && paddr != `HOST_DEV;
			case (paddr)
				`HOST_CMD:    n.prdata = {16'h0000, s.wdata, s.i2c, s.wr, s.raddr};
				`HOST_STATUS: n.prdata = {8'h00, s.prefix, s.rdata, 6'h00, s.nack, s.ph};
				`HOST_DEV:    n.prdata = {25'h0000000, s.dev};
				default:      n.prdata = 32'h00000000;
			endcase
		end
		if (psel && penable && pwrite) begin
			if (paddr == `HOST_DEV) begin
				n.dev = pwdata[6:0];
			end else if (paddr == `HOST_CMD && s.ph == gyro_link_pkg::H_IDLE) begin
				{n.wdata, n.i2c, n.wr, n.raddr} = pwdata[15:0];
				n.ph = gyro_link_pkg::H_RUN;
				n.step = 3'h0;
				n.bb = 4'h0;
				n.q = 2'h0;
				n.qcnt = 8'h00;
				n.nack = 1'b0;
			end
		end
		if (s.ph == gyro_link_pkg::H_RUN) begin
			n.qcnt = tick ? 8'h00 : s.qcnt + 8'h01;
			if (tick) begin
				n.q = s.q + 2'h1;
				if (s.q == 2'h2) begin
					if (sy.kind == gyro_link_pkg::K_BYTE && !s.i2c) begin
						n.sh = {s.sh[14:0], s.f[0]};
					end else if (sy.kind == gyro_link_pkg::K_RBYTE && !last_bit) begin
						n.sh = {s.sh[14:0], s.f[1]};
					end else if (sy.kind == gyro_link_pkg::K_BYTE && last_bit && s.f[1]) begin
						n.nack = 1'b1;
					end
				end
				if (s.q == 2'h3) begin
					if ((sy.kind == gyro_link_pkg::K_BYTE || sy.kind == gyro_link_pkg::K_RBYTE)
						&& !last_bit) begin
						n.bb = s.bb + 4'h1;
					end else begin
						n.bb = 4'h0;
						n.step = s.step + 3'h1;
					end
				end
			end
			if (sy.kind == gyro_link_pkg::K_END) begin
				n.ph = gyro_link_pkg::H_IDLE;
				n.rdata = s.sh[7:0];
				if (!s.i2c) begin
					n.prefix = s.sh[15:8];
				end
			end
		end
		// Pin levels for the coming quarter; data moves while the clock is low, except in start and stop, where it moves with the clock high
		n.sck = s.i2c;
		n.sel_n = 1'b1;
		n.d = 1'b0;
		n.oe = 1'b0;
		if (n.ph == gyro_link_pkg::H_RUN) begin
			case (sym(n).kind)
				gyro_link_pkg::K_CS_ON: begin
					n.sck = 1'b0;
					n.sel_n = 1'b0;
					n.oe = 1'b1;
				end
				gyro_link_pkg::K_CS_OFF: begin
					n.sck = 1'b0;
				end
				gyro_link_pkg::K_START: begin
					n.sck = n.q == 2'h1 || n.q == 2'h2;
					n.oe = n.q[1];
				end
				gyro_link_pkg::K_STOP: begin
					n.sck = n.q != 2'h0;
					n.oe = ~n.q[1];
				end
				gyro_link_pkg::K_BYTE, gyro_link_pkg::K_RBYTE: begin
					n.sck = n.q == 2'h1 || n.q == 2'h2; // [R16]
					n.sel_n = n.i2c;
					if (n.bb < `I2C_BYTE_BITS && sym(n).kind == gyro_link_pkg::K_BYTE) begin
						bv = sym(n).data[3'(4'h7 - n.bb)];
					end
					n.d = n.i2c ? 1'b0 : bv;
					n.oe = n.i2c ? ~bv : 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s <= '0;
			s.m1 <= 2'h2;
			s.m2 <= 2'h2;
			s.m3 <= 2'h2;
			s.f <= 2'h2;
			s.ph <= gyro_link_pkg::H_IDLE;
			s.dev <= `HOST_DEV_RESET;
			s.sel_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign link.sck = s.sck;
	assign link.select_n = s.sel_n;
	assign link.host_sda_o = s.d;
	assign link.host_sda_oe = s.oe;
	assign prdata = s.prdata;
	assign pslverr = s.err & psel & penable;
	assign pready = psel & penable;
endmodule // gyro_port_host
`default_nettype wire

// file: sim/gyro_link_sva.sv
// Checker on the serial link between the gyro port's two ends.
// Assumes it is instantiated beside the link interface with its signals wired by name.
`timescale 1ns/1ns
`default_nettype none
module gyro_link_sva (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sck,
	input wire logic select_n,
	input wire logic host_sda_o,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic miso
);
	logic       sck_d_r;
	logic [4:0] rise_cnt_r;
	logic       wr_r;
	logic       sck_rise;
	assign sck_rise = sck & ~sck_d_r;
	// Counts clock rises of a four-wire frame and keeps its direction bit
	always_ff @(posedge clk_sys) begin
		sck_d_r <= sck;
		if (!rstn || select_n) begin
			rise_cnt_r <= 5'h00;
			wr_r       <= 1'b0;
		end else if (sck_rise) begin
			rise_cnt_r <= rise_cnt_r + 5'h01;
			if (rise_cnt_r == 5'h06) begin
				wr_r <= host_sda_o;
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	frame_length_a: assert property ($rose(select_n) |-> rise_cnt_r == 5'h10)
		else $error("four-wire frame not sixteen clocks long");
	select_quiet_a: assert property ($changed(select_n) |-> !sck)
		else $error("select moved while clock high");
	prefix_one_a: assert property (sck_rise && rise_cnt_r == 5'h06 |-> miso)
		else $error("seventh prefix bit not one");
	prefix_zero_a: assert property (sck_rise && (rise_cnt_r inside {5'h01, 5'h05, 5'h07}) |-> !miso)
		else $error("fixed prefix bit not zero");
	write_zeros_a: assert property (sck_rise && wr_r && rise_cnt_r >= 5'h08 |-> !miso)
		else $error("data out not zero during write");
	miso_fall_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
		else $error("serial out changed while clock high");
	miso_release_a: assert property (select_n [*8] |-> !miso_oe)
		else $error("serial out driven while deselected");
	miso_drive_a: assert property ($fell(select_n) |-> ##[1:8] miso_oe)
		else $error("serial out not driven after select");
	host_data_hold_a: assert property (!select_n && sck && sck_d_r |-> $stable(host_sda_o))
		else $error("host data changed while clock high");
	ack_two_wire_a: assert property (dev_sda_oe |-> select_n && !dev_sda_o)
		else $error("device pulled data line outside two-wire use");
	cover property ($rose(select_n) && wr_r);
	cover property (sck_rise && rise_cnt_r == 5'h0F);
	cover property ($rose(dev_sda_oe));
endmodule // gyro_link_sva
`default_nettype wire

// file: sim/gyro_serial_register_port_tb.sv
// Testbench: the controller end, driven over APB, talks to the sensor end.
// Assumes rtl/ on the include path and the design files compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "gyro_link_map.svh"
module gyro_serial_register_port_tb;
	logic               clk_sys;
	logic               rstn;
	logic [7:0]         paddr;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic [`RATE_W-1:0] rate_x;
	logic [`RATE_W-1:0] rate_y;
	logic [`RATE_W-1:0] rate_z;
	logic [`RATE_W-1:0] rt;
	logic               sample_valid;
	logic [7:0]         control_out;
	logic [31:0]        rd;
	logic               er;
	int                 n_errors;
	int                 total_checks;
	gyro_link_if link_bus();
	gyro_port_device #(.TRIM_VALUE(8'h5A)) gyro_port_device_inst (.clk_sys(clk_sys), .rstn(rstn),
		.link(link_bus.device), .rate_x(rate_x), .rate_y(rate_y), .rate_z(rate_z),
		.sample_valid(sample_valid), .control_out(control_out));
	gyro_port_host gyro_port_host_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link_bus.host),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	gyro_link_sva gyro_link_sva_inst (.clk_sys(clk_sys), .rstn(rstn), .sck(link_bus.sck),
		.select_n(link_bus.select_n), .host_sda_o(link_bus.host_sda_o),
		.dev_sda_o(link_bus.dev_sda_o), .dev_sda_oe(link_bus.dev_sda_oe),
		.miso_o(link_bus.miso_o), .miso_oe(link_bus.miso_oe), .miso(link_bus.miso));
	always #5 clk_sys = ~clk_sys;
	task automatic complete_run;
		if (n_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer, entered right after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Starts a link transfer and polls until the controller is idle again
	task automatic xfer(input logic two, input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		apb(1'b1, `HOST_CMD, {16'h0000, d, two, w, a});
		n = 0;
		do begin
			apb(1'b0, `HOST_STATUS, 32'h0000_0000);
			n++;
		end while (rd[0] !== 1'b0 && n < 5000);
		if (rd[0] !== 1'b0) begin
			n_errors++;
		end
	endtask
	task automatic rd_reg(input logic two, input logic [5:0] a, input logic [7:0] exp,
		input string name);
		xfer(two, 1'b0, a, 8'h00);
		chk(name, {24'h000000, exp}, {24'h000000, rd[15:8]});
	endtask
	initial begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		rate_x = 13'h0000;
		rate_y = 13'h0000;
		rate_z = 13'h0000;
		sample_valid = 1'b0;
		link_bus.miso_strap = 1'b0;
		n_errors = 0;
		total_checks = 0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		apb(1'b0, `HOST_DEV, 32'h0000_0000);
		chk("dev_addr", 32'h0000_001E, {25'h0000000, rd[6:0]});
		chk("control_reset", 32'h0000_0000, {24'h000000, control_out});
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("unmapped_err", 32'h0000_0001, {31'h00000000, er});
		chk("unmapped_data", 32'h0000_0000, rd);
		rate_x <= 13'h1F05;
		rate_z <= 13'h0ABC;
		sample_valid <= 1'b1;
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		xfer(1'b0, 1'b0, `REG_STATUS, 8'h00);
		chk("prefix_por", 32'h0000_003A, {24'h000000, rd[23:16]});
		chk("status_por", 32'h0000_0008, {24'h000000, rd[15:8]});
		xfer(1'b0, 1'b0, `REG_STATUS, 8'h00);
		chk("prefix_plain", 32'h0000_0002, {24'h000000, rd[23:16]});
		for (int i = 0; i < 6; i++) begin
			rt = (i < 2) ? rate_x : ((i < 4) ? rate_y : rate_z);
			rd_reg(1'b0, `REG_RATE_FIRST + 6'(i), i[0] ? {2'b00, rt[12:7]} : {rt[6:0], 1'b0}, "rate");
		end
		xfer(1'b0, 1'b1, `REG_CONTROL, 8'h5F);
		chk("write_zeros", 32'h0000_0000, {24'h000000, rd[15:8]});
		chk("control_spi", {24'h000000, 8'h5F & `CTRL_WMASK}, {24'h000000, control_out});
		xfer(1'b1, 1'b0, `REG_CONTROL, 8'h00);
		chk("tw_disabled", 32'h0000_0001, {31'h00000000, rd[1]});
		xfer(1'b0, 1'b1, `REG_CONTROL, 8'h00);
		rd_reg(1'b1, 6'h0D, {2'b00, rate_x[12:7]}, "tw_read");
		chk("tw_ack", 32'h0000_0000, {31'h00000000, rd[1]});
		link_bus.miso_strap <= 1'b1;
		xfer(1'b1, 1'b0, `REG_CONTROL, 8'h00);
		chk("tw_strap_nack", 32'h0000_0001, {31'h00000000, rd[1]});
		apb(1'b1, `HOST_DEV, 32'h0000_001F);
		rd_reg(1'b1, `REG_CONTROL, 8'h00, "tw_odd_addr");
		chk("tw_odd_ack", 32'h0000_0000, {31'h00000000, rd[1]});
		xfer(1'b1, 1'b1, `REG_CONTROL, 8'h05);
		chk("tw_write", 32'h0000_0005, {24'h000000, control_out});
		rd_reg(1'b0, `REG_CONTROL, 8'h05, "control_back");
		rd_reg(1'b0, `REG_TWA, 8'h0F, "twa_reset");
		rd_reg(1'b0, `REG_TRIM, 8'h5A, "trim");
		// New sample arrives while select is low: the frame still reads the old one
		fork
			rd_reg(1'b0, `REG_RATE_FIRST, 8'h0A, "rate_frozen");
			begin
				wait (link_bus.select_n === 1'b0);
				repeat (8) @(posedge clk_sys);
				rate_x <= 13'h0003;
				sample_valid <= 1'b1;
				@(posedge clk_sys);
				sample_valid <= 1'b0;
			end
		join
		rd_reg(1'b0, `REG_RATE_FIRST, 8'h06, "rate_fresh");
		complete_run;
	end
	// Cuts a hang short
	initial begin
		repeat (90000) @(posedge clk_sys);
		n_errors++;
		complete_run;
	end
endmodule // gyro_serial_register_port_tb
`default_nettype wire
